// [verilog/fer_reporter.sv]
// emergency reporter: maps CAN faults to internal codes and frames, and module alarms to frames only
// assumes events and received frames come from logic on mclk_i, one cycle pulses
//
// Operation
// - Error passive raises 4503 and sends emergency 8120, register 11, module bytes zero.
// - Bus off raises 4504, disconnects from the bus and sends nothing.
// - Transmit overflow raises 4506 and sends 8110, register 11, first module byte 2.
// - Failed controller start raises critical code c507 and sends no frame.
// - Guarding loss raises 4508 and sends 8130, register 11, module bytes zero.
// - Module alarms send ff01, ff02 or ff03 with register 81, index and four diag bytes.
// - The error register byte in a frame mirrors the error register object.
// - Emergencies use identifier 80 plus node address and eight data bytes.
// - The code sits in the first two bytes low first, then the error register.
// - Byte four holds the faulty module position and bytes five to eight its diag.
// - Status bit 30 lands in bit 6 of the first diag byte; a one means fault.
// - Module status is served at index 3100 with subindex equal to position plus three.
// - Two emergency states exist; ff01 enters the error state and the clear frame 0000 leaves it.
// - An upload is answered with command 42, echoed index and subindex, then data.
`timescale 1ns/100ps
module fer_reporter (
	input  wire logic                  mclk_i,
	input  wire logic                  rst_i,
	input  wire logic [6:0]            node_id_i,
	input  wire fer_pkg::fer_can_evt_t can_evt_i,
	input  wire logic                  mod_evt_valid_i,
	input  wire fer_pkg::fer_mod_evt_t mod_evt_i,
	output logic                       mod_evt_ready_o,
	input  wire logic                  sdo_rx_valid_i,
	input  wire fer_pkg::fer_frame_t   sdo_rx_i,
	output logic                       tx_valid_o,
	output fer_pkg::fer_frame_t        tx_frame_o,
	input  wire logic                  tx_ready_i,
	output logic                       sb_valid_o,
	output logic [15:0]                sb_code_o,
	output logic                       sb_critical_o,
	output logic                       bus_off_o,
	output logic                       emcy_error_o,
	output logic [7:0]                 err_reg_o
);
	localparam int FW = $bits(fer_pkg::fer_frame_t);
	localparam int LW = $clog2(fer_pkg::FIFO_DEPTH) + 1;

	typedef struct packed {
		logic [fer_pkg::NMOD-1:0][31:0] stat;
		logic [fer_pkg::NMOD-1:0]       err_map;
		fer_pkg::fer_emcy_st_t          st;
		logic [7:0]                     err_reg;
		logic [31:0]                    hist;
		logic [4:0]                     sb_pend;
		logic [2:0]                     em_pend;
		logic                           bus_off;
		logic                           mod_rdy;
		logic                           sb_valid;
		logic [15:0]                    sb_code;
		logic                           sb_crit;
		logic                           tx_valid;
		fer_pkg::fer_frame_t            tx;
	} fer_rep_state_t;

	fer_rep_state_t      q;
	fer_rep_state_t      d;
	logic                push;
	fer_pkg::fer_frame_t push_frame;
	logic                mod_take;
	logic                sdo_take;
	logic                pos_ok;
	logic [3:0]          idx;
	logic [fer_pkg::NMOD-1:0] oh;
	logic [fer_pkg::NMOD-1:0] others;
	logic [4:0]          sb_clr;
	logic                found;
	logic [10:0]         emcy_id;
	logic [31:0]         rsp_word;
	logic                fifo_wr_ready;
	logic                fifo_rd_valid;
	logic                fifo_rd_ready;
	logic [FW-1:0]       fifo_rd_data;
	logic [LW-1:0]       fifo_level;
	logic                sdo_valid;
	fer_pkg::fer_frame_t sdo_frame;
	logic                sdo_hist;
	logic [3:0]          sdo_pos;

	// ****************************************
	// submodules
	// ****************************************
	fer_fifo #(
		.W     (FW),
		.DEPTH (fer_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk_i     (mclk_i),
		.rst_i      (rst_i),
		.wr_valid_i (push),
		.wr_ready_o (fifo_wr_ready),
		.wr_data_i  (push_frame),
		.rd_valid_o (fifo_rd_valid),
		.rd_ready_i (fifo_rd_ready),
		.rd_data_o  (fifo_rd_data),
		.level_o    (fifo_level)
	);

	fer_sdo u_sdo (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.node_id_i   (node_id_i),
		.req_valid_i (sdo_rx_valid_i),
		.req_i       (sdo_rx_i),
		.rsp_taken_i (sdo_take),
		.rsp_valid_o (sdo_valid),
		.rsp_o       (sdo_frame),
		.rsp_hist_o  (sdo_hist),
		.rsp_pos_o   (sdo_pos)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d          = q;
		d.sb_valid = 1'b0;
		push       = 1'b0;
		push_frame = '0;
		mod_take   = 1'b0;
		sdo_take   = 1'b0;
		sb_clr     = '0;
		found      = 1'b0;
		oh         = '0;
		others     = '0;
		rsp_word   = '0;
		emcy_id    = fer_pkg::ID_EMCY + {4'h0, node_id_i};
		idx        = mod_evt_i.faulty_module_index - 4'h1;
		pos_ok     = mod_evt_i.faulty_module_index != 4'h0
			&& mod_evt_i.faulty_module_index <= 4'(fer_pkg::NMOD);

		// internal codes, critical only for init failure
		for (int i = 0; i < 5; i++) begin
			if (q.sb_pend[i] && !found) begin
				found      = 1'b1;
				sb_clr[i]  = 1'b1;
				d.sb_valid = 1'b1;
				d.sb_code  = fer_pkg::SB_CODES[i];
				d.sb_crit  = i == fer_pkg::EV_INIT;
			end
		end
		// an event in the cycle its pending bit is served is kept
		d.sb_pend = (q.sb_pend & ~sb_clr) | can_evt_i;
		d.bus_off = q.bus_off | can_evt_i.bus_off;

		// accepted module alarms go first; the ready margin guarantees room
		if (mod_evt_valid_i && q.mod_rdy) begin
			mod_take = 1'b1;
			if (pos_ok) begin
				oh[idx]        = 1'b1;
				others         = q.err_map & ~oh;
				// status word stored as reported, bit 31 at top of first diag byte
				d.stat[idx]    = mod_evt_i.module_diag_bytes;
				d.err_map[idx] = mod_evt_i.incoming;
				push_frame = fer_pkg::fer_make_frame(emcy_id,
					q.st == fer_pkg::FER_ST_FREE ? fer_pkg::EM_INCOMING : fer_pkg::EM_MORE,
					fer_pkg::EREG_MOD, {4'h0, mod_evt_i.faulty_module_index},
					mod_evt_i.module_diag_bytes);
				if (mod_evt_i.incoming) begin
					push = 1'b1;
					d.st = fer_pkg::FER_ST_ERROR;
				end else if (q.st == fer_pkg::FER_ST_ERROR && others != '0) begin
					push = 1'b1;
					push_frame.data[0] = fer_pkg::EM_OUTGOING[7:0];
					push_frame.data[1] = fer_pkg::EM_OUTGOING[15:8];
				end else if (q.st == fer_pkg::FER_ST_ERROR) begin
					push = 1'b1;
					push_frame = fer_pkg::fer_make_frame(emcy_id, fer_pkg::EM_CLEAR,
						fer_pkg::EREG_NONE, 8'h00, 32'h0000_0000);
					d.st = fer_pkg::FER_ST_FREE;
				end
				// history keeps the diag of the last frame pushed with register 81
				if (push && push_frame.data[2] == fer_pkg::EREG_MOD) begin
					d.hist = mod_evt_i.module_diag_bytes;
				end
			end
		end else if (fifo_wr_ready && q.em_pend[0]) begin
			push = 1'b1;
			push_frame = fer_pkg::fer_make_frame(emcy_id, fer_pkg::EM_PASSIVE,
				fer_pkg::EREG_CAN, 8'h00, 32'h0000_0000);
			d.em_pend[0] = 1'b0;
		end else if (fifo_wr_ready && q.em_pend[1]) begin
			// overflow frame, first module byte 2
			push = 1'b1;
			push_frame = fer_pkg::fer_make_frame(emcy_id, fer_pkg::EM_TXOVF,
				fer_pkg::EREG_CAN, fer_pkg::TXOVF_BYTE, 32'h0000_0000);
			d.em_pend[1] = 1'b0;
		end else if (fifo_wr_ready && q.em_pend[2]) begin
			push = 1'b1;
			push_frame = fer_pkg::fer_make_frame(emcy_id, fer_pkg::EM_GUARD,
				fer_pkg::EREG_CAN, 8'h00, 32'h0000_0000);
			d.em_pend[2] = 1'b0;
		end else if (fifo_wr_ready && sdo_valid) begin
			// status or history word appended to the upload answer
			rsp_word = sdo_hist ? q.hist : q.stat[sdo_pos - 4'h1];
			push = 1'b1;
			sdo_take = 1'b1;
			push_frame = sdo_frame;
			push_frame.data[4] = rsp_word[31:24];
			push_frame.data[5] = rsp_word[23:16];
			push_frame.data[6] = rsp_word[15:8];
			push_frame.data[7] = rsp_word[7:0];
		end
		d.em_pend = d.em_pend | {can_evt_i.guard, can_evt_i.tx_ovf, can_evt_i.passive};
		// error register object follows every emergency sent
		if (push && !sdo_take) begin
			d.err_reg = push_frame.data[2];
		end
		// disconnected: nothing more enters the transmit path
		if (q.bus_off) begin
			push = 1'b0;
		end
		// registered ready lags a cycle, so keep room for the push in flight
		d.mod_rdy = fifo_level <= LW'(fer_pkg::FIFO_DEPTH - fer_pkg::FIFO_SLACK);

		// output register so the transmit port comes from flops
		fifo_rd_ready = (!q.tx_valid || tx_ready_i) && !q.bus_off;
		if (fifo_rd_ready) begin
			d.tx_valid = fifo_rd_valid;
			d.tx       = fifo_rd_data;
		end else if (q.bus_off) begin
			d.tx_valid = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign mod_evt_ready_o = q.mod_rdy;
	assign tx_valid_o      = q.tx_valid;
	assign tx_frame_o      = q.tx;
	assign sb_valid_o      = q.sb_valid;
	assign sb_code_o       = q.sb_code;
	assign sb_critical_o   = q.sb_crit;
	assign bus_off_o       = q.bus_off;
	assign emcy_error_o    = q.st == fer_pkg::FER_ST_ERROR;
	assign err_reg_o       = q.err_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_passive_frame: assert property (
		push && push_frame.data[1:0] == 16'h8120 |-> push_frame.data[2] == 8'h11
		&& push_frame.data[7:3] == '0) else $error("passive frame content wrong");
	a_busoff_hold: assert property (
		bus_off_o |=> bus_off_o && !tx_valid_o) else $error("bus off not held");
	a_busoff_code: assert property (
		can_evt_i.bus_off |-> ##[1:5] (sb_valid_o && sb_code_o == 16'h4504))
		else $error("bus off code not raised");
	a_txovf_frame: assert property (
		push && push_frame.data[1:0] == 16'h8110 |-> push_frame.data[3] == 8'h02
		&& push_frame.data[2] == 8'h11) else $error("overflow frame content wrong");
	a_init_crit: assert property (
		sb_valid_o |-> sb_critical_o == (sb_code_o == 16'hc507))
		else $error("critical class wrong");
	a_guard_frame: assert property (
		push && push_frame.data[1:0] == 16'h8130 |-> push_frame.data[2] == 8'h11
		&& push_frame.data[7:3] == '0) else $error("guarding frame content wrong");
	a_first_incoming: assert property (
		push && push_frame.data[1:0] == 16'hff01 |-> !emcy_error_o
		&& push_frame.data[2] == 8'h81 ##1 emcy_error_o) else $error("ff01 out of state");
	a_ereg_mirror: assert property (
		push && push_frame.id == emcy_id |=> err_reg_o == $past(push_frame.data[2]))
		else $error("error register not mirrored");
	a_frame_id: assert property (
		tx_valid_o && tx_frame_o.id[10:8] == 3'h0 |-> tx_frame_o.id == emcy_id
		&& tx_frame_o.dlc == 4'h8) else $error("emergency identifier wrong");
	a_diag_pack: assert property (
		mod_take && pos_ok && mod_evt_i.incoming |-> push_frame.data[4][6]
		== mod_evt_i.module_diag_bytes[30] && push_frame.data[3][3:0]
		== mod_evt_i.faulty_module_index) else $error("diag bytes misplaced");
	a_clear_zero: assert property (
		push && push_frame.id == emcy_id && push_frame.data[1:0] == 16'h0000
		|-> push_frame.data[7:2] == '0 ##1 !emcy_error_o) else $error("clear frame wrong");
	a_hist_store: assert property (
		push && push_frame.data[2] == 8'h81 && mod_take
		|=> q.hist == $past(mod_evt_i.module_diag_bytes)) else $error("history not stored");

	c_incoming: cover property (push && push_frame.data[1:0] == 16'hff01);
	c_all_clear: cover property (push && push_frame.id == emcy_id && push_frame.data[1:0] == 0);
	c_upload: cover property (sdo_take);
	c_stall: cover property ((tx_valid_o && !tx_ready_i)[*3]);

endmodule : fer_reporter

// [common/fer_pkg.sv]
// constants, carriers and frame builder of the emergency reporter
// assumes one 10 MHz clock shared by the reporter and the CAN controller logic
package fer_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NMOD       = 14;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_SLACK = 3;

	// ****************************************
	// internal safety bus codes, one per CAN event
	// ****************************************
	localparam int EV_PASSIVE = 0;
	localparam int EV_BUSOFF  = 1;
	localparam int EV_TXOVF   = 2;
	localparam int EV_INIT    = 3;
	localparam int EV_GUARD   = 4;
	localparam logic [15:0] SB_PASSIVE  = 16'h4503;
	localparam logic [15:0] SB_BUSOFF   = 16'h4504;
	localparam logic [15:0] SB_TXOVF    = 16'h4506;
	localparam logic [15:0] SB_INITFAIL = 16'hc507;
	localparam logic [15:0] SB_GUARD    = 16'h4508;
	localparam logic [4:0][15:0] SB_CODES = {SB_GUARD, SB_INITFAIL, SB_TXOVF, SB_BUSOFF,
		SB_PASSIVE};

	// ****************************************
	// emergency codes and error register values
	// ****************************************
	localparam logic [15:0] EM_PASSIVE  = 16'h8120;
	localparam logic [15:0] EM_TXOVF    = 16'h8110;
	localparam logic [15:0] EM_GUARD    = 16'h8130;
	localparam logic [15:0] EM_INCOMING = 16'hff01;
	localparam logic [15:0] EM_OUTGOING = 16'hff02;
	localparam logic [15:0] EM_MORE     = 16'hff03;
	localparam logic [15:0] EM_CLEAR    = 16'h0000;
	localparam logic [7:0]  EREG_CAN    = 8'h11;
	localparam logic [7:0]  EREG_MOD    = 8'h81;
	localparam logic [7:0]  EREG_NONE   = 8'h00;
	localparam logic [7:0]  TXOVF_BYTE  = 8'h02;

	// ****************************************
	// identifiers and service data objects
	// ****************************************
	localparam logic [10:0] ID_EMCY       = 11'h080;
	localparam logic [10:0] ID_SDO_RX     = 11'h600;
	localparam logic [10:0] ID_SDO_TX     = 11'h580;
	localparam logic [3:0]  DLC_FULL      = 4'h8;
	localparam logic [7:0]  SDO_UP_REQ    = 8'h40;
	localparam logic [7:0]  SDO_UP_RSP    = 8'h42;
	localparam logic [15:0] IDX_STATUS    = 16'h3100;
	localparam logic [15:0] IDX_HISTORY   = 16'h1003;
	localparam logic [7:0]  SUB_MOD_BASE  = 8'h03;
	localparam logic [7:0]  SUB_HIST_LAST = 8'h01;

	typedef enum logic {
		FER_ST_FREE  = 1'b0,
		FER_ST_ERROR = 1'b1
	} fer_emcy_st_t;

	typedef struct packed {
		logic [10:0]     id;
		logic [3:0]      dlc;
		logic [7:0][7:0] data;
	} fer_frame_t;

	typedef struct packed {
		logic guard;
		logic init_fail;
		logic tx_ovf;
		logic bus_off;
		logic passive;
	} fer_can_evt_t;

	typedef struct packed {
		logic        incoming;
		logic [3:0]  faulty_module_index;
		logic [31:0] module_diag_bytes;
	} fer_mod_evt_t;

	// byte 0/1 code low first, byte 2 error register, byte 3 index, then diag high first
	function automatic fer_frame_t fer_make_frame(input logic [10:0] id, input logic [15:0] code,
		input logic [7:0] ereg, input logic [7:0] pos, input logic [31:0] diag);
		fer_frame_t f;
		f.id      = id;
		f.dlc     = DLC_FULL;
		f.data[0] = code[7:0];
		f.data[1] = code[15:8];
		f.data[2] = ereg;
		f.data[3] = pos;
		f.data[4] = diag[31:24];
		f.data[5] = diag[23:16];
		f.data[6] = diag[15:8];
		f.data[7] = diag[7:0];
		return f;
	endfunction : fer_make_frame

endpackage : fer_pkg

// [verilog/fer_fifo.sv]
// first-in first-out buffer of frames between the reporter and the CAN transmitter
// assumes writer and reader share the clock; depth is a power of two
`timescale 1ns/100ps
module fer_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wr_valid_i,
	output logic                          wr_ready_o,
	input  wire logic [W-1:0]             wr_data_i,
	output logic                          rd_valid_o,
	input  wire logic                     rd_ready_i,
	output logic [W-1:0]                  rd_data_o,
	output logic [$clog2(DEPTH):0]        level_o
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fer_fifo_state_t;

	fer_fifo_state_t q;
	fer_fifo_state_t d;
	logic            push;
	logic            pop;

	assign wr_ready_o = q.cnt != (AW + 1)'(DEPTH);
	assign rd_valid_o = q.cnt != '0;
	assign rd_data_o  = q.mem[q.rp];
	assign level_o    = q.cnt;

	always_comb begin
		d    = q;
		push = wr_valid_i && wr_ready_o;
		pop  = rd_ready_i && rd_valid_o;
		if (push) begin
			d.mem[q.wp] = wr_data_i;
			d.wp        = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	a_fifo_full_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		!wr_ready_o && !rd_ready_i |=> !wr_ready_o && level_o == $past(level_o))
		else $error("fifo level moved while full and stalled");

endmodule : fer_fifo

// [verilog/fer_sdo.sv]
// expedited upload server: decodes read requests and holds one answer header
// assumes requests come from the CAN receiver on the same clock, one frame per pulse
`timescale 1ns/100ps
module fer_sdo (
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	input  wire logic [6:0]          node_id_i,
	input  wire logic                req_valid_i,
	input  wire fer_pkg::fer_frame_t req_i,
	input  wire logic                rsp_taken_i,
	output logic                     rsp_valid_o,
	output fer_pkg::fer_frame_t      rsp_o,
	output logic                     rsp_hist_o,
	output logic [3:0]               rsp_pos_o
);
	typedef struct packed {
		logic                busy;
		fer_pkg::fer_frame_t frame;
		logic                hist;
		logic [3:0]          pos;
	} fer_sdo_state_t;

	fer_sdo_state_t q;
	fer_sdo_state_t d;
	logic [15:0]    index;
	logic [7:0]     sub;
	logic           hit_stat;
	logic           hit_hist;
	logic           addr_ok;

	assign rsp_valid_o = q.busy;
	assign rsp_o       = q.frame;
	assign rsp_hist_o  = q.hist;
	assign rsp_pos_o   = q.pos;

	always_comb begin
		d     = q;
		index = {req_i.data[2], req_i.data[1]};
		sub   = req_i.data[3];
		addr_ok = req_i.id == fer_pkg::ID_SDO_RX + {4'h0, node_id_i}
			&& req_i.dlc == fer_pkg::DLC_FULL && req_i.data[0] == fer_pkg::SDO_UP_REQ;
		hit_stat = index == fer_pkg::IDX_STATUS && sub > fer_pkg::SUB_MOD_BASE
			&& sub <= fer_pkg::SUB_MOD_BASE + 8'(fer_pkg::NMOD);
		hit_hist = index == fer_pkg::IDX_HISTORY && sub == fer_pkg::SUB_HIST_LAST;
		if (rsp_taken_i) begin
			d.busy = 1'b0;
		end
		// one answer outstanding; a request arriving meanwhile is dropped, master retries
		if (!q.busy && req_valid_i && addr_ok && (hit_stat || hit_hist)) begin
			d.busy  = 1'b1;
			d.hist  = hit_hist;
			d.pos   = 4'(sub - fer_pkg::SUB_MOD_BASE);
			d.frame = fer_pkg::fer_make_frame(fer_pkg::ID_SDO_TX + {4'h0, node_id_i},
				{req_i.data[1], fer_pkg::SDO_UP_RSP}, req_i.data[2], sub, 32'h0000_0000);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	a_sdo_echo: assert property (@(posedge mclk_i) disable iff (rst_i)
		!rsp_valid_o && req_valid_i && addr_ok && hit_stat |=> rsp_valid_o
		&& rsp_o.data[0] == 8'h42 && rsp_o.data[3] == $past(req_i.data[3]))
		else $error("upload answer missing or not echoing subindex");
	a_sdo_pos: assert property (@(posedge mclk_i) disable iff (rst_i)
		rsp_valid_o && !rsp_hist_o |-> rsp_pos_o == 4'(rsp_o.data[3] - 8'h03))
		else $error("status answer position not subindex minus three");

endmodule : fer_sdo

// [tb/fer_master_model.sv]
// far-side master model: takes emergency frames and sends upload requests
// assumes one shared clock; drives its outputs at the falling edge
`timescale 1ns/100ps
module fer_master_model (
	input  wire logic                mclk_i,
	input  wire logic                tx_valid_i,
	input  wire fer_pkg::fer_frame_t tx_frame_i,
	output logic                     tx_ready_o,
	output logic                     req_valid_o,
	output fer_pkg::fer_frame_t      req_o
);
	// ****************************************
	// receive and request
	// ****************************************
	fer_pkg::fer_frame_t got[$];
	logic                stall = 1'b0;
	initial begin
		tx_ready_o  = 1'b0;
		req_valid_o = 1'b0;
		req_o       = '0;
	end
	// a stalled master backs frames up into the reporter fifo
	always @(negedge mclk_i) tx_ready_o <= !stall;
	always @(posedge mclk_i) if (tx_valid_i && tx_ready_o) got.push_back(tx_frame_i);
	task automatic upload(input logic [6:0] nd, input logic [15:0] ix, input logic [7:0] sb);
		@(negedge mclk_i);
		req_o       = {11'h600 + {4'h0, nd}, 4'h8, 32'h0, sb, ix, 8'h40};
		req_valid_o = 1'b1;
		@(negedge mclk_i);
		req_valid_o = 1'b0;
		// released bus no longer shows the request
		req_o       = ~req_o;
	endtask : upload
endmodule : fer_master_model

// [tb/fer_reporter_test.sv]
// self-checking bench of the emergency reporter
// assumes the master model answers transmit frames; inputs move at the falling edge
`timescale 1ns/100ps
module fer_reporter_test;
	logic                  mclk_i, rst_i, mev_v, sdo_v, tx_v, tx_rdy, sb_v, sb_crit, boff, emerr;
	logic                  mev_rdy;
	logic [6:0]            node = 7'h0c;
	logic [15:0]           sb_code;
	logic [7:0]            ereg;
	fer_pkg::fer_can_evt_t can;
	fer_pkg::fer_mod_evt_t mev;
	fer_pkg::fer_frame_t   sdo, txf, f;
	wire logic [10:0]      em = 11'h080 + {4'h0, node};
	int                    num_errors = 0;
	int                    samples_checked = 0;
	int                    n, k;
	fer_reporter fer_reporter_i (.mclk_i(mclk_i), .rst_i(rst_i), .node_id_i(node),
		.can_evt_i(can), .mod_evt_valid_i(mev_v), .mod_evt_i(mev), .mod_evt_ready_o(mev_rdy),
		.sdo_rx_valid_i(sdo_v), .sdo_rx_i(sdo), .tx_valid_o(tx_v), .tx_frame_o(txf),
		.tx_ready_i(tx_rdy), .sb_valid_o(sb_v), .sb_code_o(sb_code), .sb_critical_o(sb_crit),
		.bus_off_o(boff), .emcy_error_o(emerr), .err_reg_o(ereg));
	fer_master_model fer_master_model_i (.mclk_i(mclk_i), .tx_valid_i(tx_v),
		.tx_frame_i(txf), .tx_ready_o(tx_rdy), .req_valid_o(sdo_v), .req_o(sdo));
	// ****************************************
	// helpers
	// ****************************************
	function automatic fer_pkg::fer_frame_t mk(logic [10:0] id, logic [15:0] c,
		logic [7:0] r, logic [7:0] m, logic [31:0] d);
		return {id, 4'h8, d[7:0], d[15:8], d[23:16], d[31:24], m, r, c};
	endfunction : mk
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [78:0] e, input logic [78:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic hang(input string nm);
		num_errors++;
		$display("ERROR %s expected event seen timeout", nm);
		conclude();
	endtask : hang
	task automatic take();
		for (k = 0; k < 60 && fer_master_model_i.got.size() == 0; k++) @(negedge mclk_i);
		if (k == 60) begin
			num_errors++;
			$display("ERROR tx frame expected one seen none");
			conclude();
		end else f = fer_master_model_i.got.pop_front();
	endtask : take
	task automatic exp(input string nm, input fer_pkg::fer_frame_t e);
		take();
		chk(nm, e, f);
	endtask : exp
	task automatic none(input string nm);
		repeat (20) @(negedge mclk_i);
		chk(nm, 79'(0), 79'(fer_master_model_i.got.size()));
	endtask : none
	task automatic can_evt(input int b, input logic [15:0] c, input logic cr);
		@(negedge mclk_i);
		can[b] = 1'b1;
		@(negedge mclk_i);
		can = '0;
		for (k = 0; k < 8 && sb_v !== 1'b1; k++) @(negedge mclk_i);
		if (k == 8) hang("sb valid");
		chk("sb code", 79'(c), 79'(sb_code));
		chk("sb critical", 79'(cr), 79'(sb_crit));
	endtask : can_evt
	task automatic alarm(input logic inc, input logic [3:0] p, input logic [31:0] d);
		@(negedge mclk_i);
		mev   = '{inc, p, d};
		mev_v = 1'b1;
		for (k = 0; k < 60 && mev_rdy !== 1'b1; k++) @(negedge mclk_i);
		if (k == 60) hang("alarm ready");
		chk("alarm ready", 79'(1), 79'(mev_rdy));
		@(negedge mclk_i);
		mev_v = 1'b0;
		mev   = ~mev;
	endtask : alarm
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_can();
		can_evt(fer_pkg::EV_PASSIVE, 16'h4503, 1'b0);
		exp("passive frame", mk(em, 16'h8120, 8'h11, 8'h00, 32'h0));
		chk("err reg", 79'(8'h11), 79'(ereg));
		can_evt(fer_pkg::EV_TXOVF, 16'h4506, 1'b0);
		exp("txovf frame", mk(em, 16'h8110, 8'h11, 8'h02, 32'h0));
		can_evt(fer_pkg::EV_INIT, 16'hc507, 1'b1);
		can_evt(fer_pkg::EV_GUARD, 16'h4508, 1'b0);
		exp("guard frame", mk(em, 16'h8130, 8'h11, 8'h00, 32'h0));
		chk("state", 79'(0), 79'(emerr));
		$display("test can done");
	endtask : t_can
	task automatic t_mod();
		alarm(1'b1, 4'h3, 32'h4000_0000);
		exp("incoming", mk(em, 16'hff01, 8'h81, 8'h03, 32'h4000_0000));
		chk("state", 79'(1), 79'(emerr));
		chk("err reg", 79'(8'h81), 79'(ereg));
		fer_master_model_i.upload(node, 16'h1003, 8'h01);
		exp("history", mk(11'h580 + {4'h0, node}, 16'h0342, 8'h10, 8'h01, 32'h4000_0000));
		fer_master_model_i.upload(node, 16'h3100, 8'h06);
		take();
		chk("status head", {11'h580 + {4'h0, node}, 4'h8, 32'h0631_0042}, {f[78:64], f[31:0]});
		chk("status bit", 79'(1), 79'(f.data[4][6]));
		fer_master_model_i.upload(node, 16'h3100, 8'h03);
		none("bad sub");
		alarm(1'b1, 4'hb, 32'h0000_0100);
		exp("more", mk(em, 16'hff03, 8'h81, 8'h0b, 32'h0000_0100));
		alarm(1'b0, 4'hb, 32'h0);
		exp("outgoing", mk(em, 16'hff02, 8'h81, 8'h0b, 32'h0));
		alarm(1'b0, 4'h3, 32'h0);
		exp("clear", mk(em, 16'h0, 8'h00, 8'h00, 32'h0));
		chk("state", 79'(0), 79'(emerr));
		chk("err reg", 79'(0), 79'(ereg));
		$display("test module done");
	endtask : t_mod
	task automatic t_fifo();
		fer_master_model_i.stall = 1'b1;
		n = 0;
		@(negedge mclk_i);
		mev_v = 1'b1;
		for (k = 0; k < 40 && mev_rdy === 1'b1; k++) begin
			mev = '{1'b1, 4'(k % 14 + 1), 32'(k)};
			@(negedge mclk_i);
			n++;
		end
		mev_v = 1'b0;
		chk("fifo refused", 79'(0), 79'(mev_rdy));
		// fills the last fifo slot while the master stalls
		can_evt(fer_pkg::EV_PASSIVE, 16'h4503, 1'b0);
		fer_master_model_i.stall = 1'b0;
		for (int i = 0; i < n; i++) begin
			take();
			chk("drain code", 79'(i == 0 ? 16'hff01 : 16'hff03), 79'(f.data[1:0]));
		end
		exp("queued passive", mk(em, 16'h8120, 8'h11, 8'h00, 32'h0));
		none("drain extra");
		$display("test fifo done");
	endtask : t_fifo
	task automatic t_busoff();
		can_evt(fer_pkg::EV_BUSOFF, 16'h4504, 1'b0);
		chk("bus off", 79'(1), 79'(boff));
		alarm(1'b1, 4'h5, 32'h1);
		none("after bus off");
		chk("tx valid", 79'(0), 79'(tx_v));
		$display("test bus off done");
	endtask : t_busoff
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		rst_i = 1'b1;
		can   = '0;
		mev_v = 1'b0;
		mev   = '0;
		repeat (8) @(negedge mclk_i);
		rst_i = 1'b0;
		t_can();
		t_mod();
		t_fifo();
		t_busoff();
		conclude();
	end
endmodule : fer_reporter_test
